// >>> verilog/ecu_pkg.sv
// package for the edge capture unit: register layout, codes and sizes
`default_nettype none
package ecu_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned PTR_W = 2;
  localparam int unsigned CNT_W = 3;
  // register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] BUF_OFS = 4'h1;
  // control field positions
  localparam int unsigned IDLE_BIT = 13;
  localparam int unsigned TSEL_LSB = 10;
  localparam int unsigned CPI_LSB = 5;
  localparam int unsigned OVF_BIT = 4;
  localparam int unsigned BNE_BIT = 3;
  localparam int unsigned MODE_LSB = 0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CTRL_WMASK = 16'h3C67;
  // prescaler counts
  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hF;
  localparam logic [3:0] ZERO4 = 4'h0;
  localparam logic [3:0] ONE4 = 4'h1;
  localparam logic [1:0] ONE2 = 2'h1;
  localparam logic [PTR_W-1:0] ONE_PTR = 2'h1;
  localparam logic [CNT_W-1:0] ONE_CNT = 3'h1;
  localparam logic [CNT_W-1:0] FULL_CNT = 3'h4;
  localparam logic [DATA_W-1:0] ONE_TB = 16'h0001;

  typedef enum logic [2:0] {
    MODE_OFF = 3'h0, MODE_BOTH = 3'h1, MODE_RISE = 3'h2, MODE_FALL = 3'h3,
    MODE_PRE4 = 3'h4, MODE_PRE16 = 3'h5, MODE_UNUSED = 3'h6, MODE_WAKE = 3'h7
  } ecu_mode_type;

  typedef enum logic [2:0] {
    TSEL_T3 = 3'h0, TSEL_T2 = 3'h1, TSEL_T4 = 3'h2, TSEL_T5 = 3'h3,
    TSEL_T1 = 3'h4, TSEL_RSV5 = 3'h5, TSEL_RSV6 = 3'h6, TSEL_PER = 3'h7
  } ecu_tsel_type;

  // timer clock enables, each a one-cycle tick synchronous to clk_i
  typedef struct packed {
    logic timer_one_clock;
    logic timer_two_clock;
    logic timer_three_clock;
    logic timer_four_clock;
    logic timer_five_clock;
  } ecu_ticks_type;

  // software register port
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ecu_bus_type;

  // cpu power state
  typedef struct packed {
    logic idle;
    logic sleep;
  } ecu_power_type;
endpackage : ecu_pkg
`default_nettype wire

// >>> verilog/ecu_timebase.sv
// edge capture unit: 16-bit time base with clock source selection
`default_nettype none
module ecu_timebase
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  input wire ecu_pkg::ecu_tsel_type tsel_i,
  input wire ecu_pkg::ecu_ticks_type ticks_i,
  output logic [ecu_pkg::DATA_W-1:0] count_o
);
  import ecu_pkg::*;
  logic [DATA_W-1:0] count_ff;
  logic [DATA_W-1:0] nxt_count;
  logic tick;

  // choose the counting source
  always_comb
  begin
    case (tsel_i)
      TSEL_T5: tick = ticks_i.timer_five_clock;
      TSEL_T4: tick = ticks_i.timer_four_clock;
      TSEL_T2: tick = ticks_i.timer_two_clock;
      TSEL_T3: tick = ticks_i.timer_three_clock;
      TSEL_T1: tick = ticks_i.timer_one_clock; // sync form only
      TSEL_PER: tick = 1'b1; // peripheral clock, every cycle
      default: tick = 1'b0; // reserved codes stop the count
    endcase
    nxt_count = count_ff;
    if (run_i && tick)
    begin
      nxt_count = count_ff + ONE_TB;
    end
  end

  // count register
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      count_ff <= '0;
    else
      count_ff <= nxt_count;
  end

  assign count_o = count_ff;

  a_tb_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (run_i && tsel_i == TSEL_PER) |=> count_ff == $past(count_ff) + ONE_TB)
    else $error("time base did not step on peripheral clock");
  a_tb_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tsel_i == TSEL_RSV5 || tsel_i == TSEL_RSV6) |=> $stable(count_ff))
    else $error("time base moved on reserved select");
endmodule // ecu_timebase
`default_nettype wire

// >>> verilog/ecu_fifo.sv
// edge capture unit: four-entry capture buffer
`default_nettype none
module ecu_fifo
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clear_i,
  input wire logic push_i,
  input wire logic [ecu_pkg::DATA_W-1:0] push_data_i,
  input wire logic pop_i,
  output logic [ecu_pkg::DATA_W-1:0] head_o,
  output logic empty_o,
  output logic full_o
);
  import ecu_pkg::*;
  logic [DATA_W-1:0] mem_ff [FIFO_DEPTH];
  logic [DATA_W-1:0] nxt_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic do_push, do_pop;

  assign empty_o = (cnt_ff == '0);
  assign full_o = (cnt_ff == FULL_CNT);
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;

  // pointer and count update
  always_comb
  begin
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;
    if (clear_i)
    begin
      nxt_wp = '0;
      nxt_rp = '0;
      nxt_cnt = '0;
    end
    else
    begin
      if (do_push)
        nxt_wp = wp_ff + ONE_PTR;
      if (do_pop)
        nxt_rp = rp_ff + ONE_PTR;
      if (do_push && !do_pop)
        nxt_cnt = cnt_ff + ONE_CNT;
      else if (do_pop && !do_push)
        nxt_cnt = cnt_ff - ONE_CNT;
    end
  end

  // storage, one entry per slot
  for (genvar g = 0; g < FIFO_DEPTH; g++)
  begin : g_slot
    always_comb
    begin
      nxt_mem[g] = mem_ff[g];
      if (do_push && !clear_i && wp_ff == PTR_W'(g))
        nxt_mem[g] = push_data_i;
    end
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
        mem_ff[g] <= '0;
      else
        mem_ff[g] <= nxt_mem[g];
    end
  end

  // pointer registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  assign head_o = mem_ff[rp_ff];

  a_fifo_bound: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cnt_ff <= FULL_CNT)
    else $error("capture buffer count beyond depth");
endmodule // ecu_fifo
`default_nettype wire

// >>> verilog/ecu_top.sv
// edge capture unit: control register, edge detection, prescaler, interrupt
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`default_nettype none
module ecu_top
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire ecu_pkg::ecu_bus_type bus_i,
  output logic [ecu_pkg::DATA_W-1:0] rdata_o,
  input wire ecu_pkg::ecu_ticks_type ticks_i,
  input wire ecu_pkg::ecu_power_type power_i,
  input wire logic capture_pin_i,
  output logic irq_o
);
  import ecu_pkg::*;

  logic [DATA_W-1:0] ctrl_ff, nxt_ctrl;
  logic ovf_ff, nxt_ovf;
  logic pin_ff, nxt_pin;
  logic [3:0] pre_ff, nxt_pre;
  logic [1:0] cpi_cnt_ff, nxt_cpi_cnt;
  logic irq_ff, nxt_irq;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  ecu_mode_type mode;
  ecu_tsel_type tsel;
  logic [1:0] cpi;
  logic idle_halt, halted, run, rise, fall, cap_ev, wake_ev;
  logic [DATA_W-1:0] tb_count, head;
  logic fifo_empty, fifo_full, pop, push;
  logic [DATA_W-1:0] status_view;

  // field views of the control register
  assign mode = ecu_mode_type'(ctrl_ff[MODE_LSB +: 3]);
  assign tsel = ecu_tsel_type'(ctrl_ff[TSEL_LSB +: 3]);
  assign cpi = ctrl_ff[CPI_LSB +: 2];
  assign idle_halt = ctrl_ff[IDLE_BIT];

  // channel runs unless off, unused, wake-only, halted in idle, or the cpu sleeps
  assign halted = idle_halt && power_i.idle;
  assign run = !halted && !power_i.sleep && (mode != MODE_OFF)
    && (mode != MODE_UNUSED) && (mode != MODE_WAKE);

  // pin edge detection
  assign nxt_pin = capture_pin_i;
  assign rise = capture_pin_i && !pin_ff;
  assign fall = !capture_pin_i && pin_ff;

  // capture event by mode, with rising-edge prescaler
  always_comb
  begin
    nxt_pre = pre_ff;
    cap_ev = 1'b0;
    if (run)
    begin
      case (mode)
        MODE_BOTH: cap_ev = rise || fall;
        MODE_RISE: cap_ev = rise;
        MODE_FALL: cap_ev = fall;
        MODE_PRE4:
        begin
          if (rise)
          begin
            cap_ev = (pre_ff >= PRE4_LAST);
            nxt_pre = cap_ev ? ZERO4 : pre_ff + ONE4;
          end
        end
        MODE_PRE16:
        begin
          if (rise)
          begin
            cap_ev = (pre_ff == PRE16_LAST);
            nxt_pre = pre_ff + ONE4;
          end
        end
        default: cap_ev = 1'b0;
      endcase
    end
    else
    begin
      nxt_pre = ZERO4;
    end
  end

  // wake pin: rising edges only, only in sleep or idle
  assign wake_ev = (mode == MODE_WAKE) && rise && (power_i.sleep || power_i.idle);

  assign push = cap_ev;
  assign pop = bus_i.rd && (bus_i.addr == BUF_OFS);

  // interrupt divider and overflow flag
  always_comb
  begin
    nxt_cpi_cnt = cpi_cnt_ff;
    nxt_irq = 1'b0;
    nxt_ovf = ovf_ff;
    if (!run)
      nxt_cpi_cnt = '0;
    if (wake_ev)
      nxt_irq = 1'b1;
    else if (cap_ev && fifo_full)
      nxt_ovf = 1'b1; // dropped capture, no interrupt
    else if (cap_ev && mode == MODE_BOTH)
      nxt_irq = 1'b1; // divider ignored
    else if (cap_ev)
    begin
      if (cpi_cnt_ff == cpi)
      begin
        nxt_irq = 1'b1;
        nxt_cpi_cnt = '0;
      end
      else
        nxt_cpi_cnt = cpi_cnt_ff + ONE2;
    end
    if (mode == MODE_OFF)
      nxt_ovf = 1'b0; // turning off clears the buffer state
  end

  // control register write and read data
  assign status_view = {ctrl_ff[DATA_W-1:OVF_BIT+1], ovf_ff, !fifo_empty, ctrl_ff[BNE_BIT-1:0]};
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (bus_i.wr && bus_i.addr == CTRL_OFS)
      nxt_ctrl = bus_i.wdata & CTRL_WMASK;
    nxt_rdata = '0;
    if (bus_i.rd)
    begin
      if (bus_i.addr == CTRL_OFS)
        nxt_rdata = status_view & (CTRL_WMASK | (ONE_TB << OVF_BIT) | (ONE_TB << BNE_BIT));
      else if (bus_i.addr == BUF_OFS)
        nxt_rdata = head; // oldest capture, empty reads the stale slot at the read pointer
      else
        nxt_rdata = '0;
    end
  end

  // state registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_ff <= CTRL_RESET;
      ovf_ff <= 1'b0;
      pin_ff <= 1'b0;
      pre_ff <= '0;
      cpi_cnt_ff <= '0;
      irq_ff <= 1'b0;
      rdata_ff <= '0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      ovf_ff <= nxt_ovf;
      pin_ff <= nxt_pin;
      pre_ff <= nxt_pre;
      cpi_cnt_ff <= nxt_cpi_cnt;
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;
  assign irq_o = irq_ff;

  // time base
  ecu_timebase u_tb
  (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(run),
    .tsel_i(tsel),
    .ticks_i(ticks_i),
    .count_o(tb_count)
  );

  // capture buffer, flushed while the channel is off
  ecu_fifo u_fifo
  (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clear_i(mode == MODE_OFF),
    .push_i(push),
    .push_data_i(tb_count),
    .pop_i(pop),
    .head_o(head),
    .empty_o(fifo_empty),
    .full_o(fifo_full)
  );

  // a capture that finds the buffer full
  sequence s_full_capture;
    cap_ev && fifo_full && mode != MODE_OFF;
  endsequence
  // a capture that finds room in the buffer
  sequence s_stored_capture;
    cap_ev && !fifo_full;
  endsequence
  // a rising pin edge while the cpu sleeps or idles in wake mode
  sequence s_wake_edge;
    mode == MODE_WAKE && rise && (power_i.sleep || power_i.idle);
  endsequence

  // overflow flag: set only by a dropped capture, held until the channel is off
  a_ovf_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_full_capture |=> ovf_ff)
    else $error("overflow not flagged on full capture");
  a_ovf_sticky: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ovf_ff && mode != MODE_OFF) |=> ovf_ff)
    else $error("overflow flag dropped");
  a_ovf_cause: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!ovf_ff && !(cap_ev && fifo_full)) |=> !ovf_ff)
    else $error("overflow flag set without a dropped capture");
  a_full_drop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cap_ev && fifo_full && !pop) |=> fifo_full)
    else $error("dropped capture changed a full buffer");
  a_ovf_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (bus_i.rd && bus_i.addr == CTRL_OFS) |=> rdata_o[OVF_BIT] == $past(ovf_ff))
    else $error("overflow flag read wrong");
  // not-empty flag and buffer contents
  a_bne_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (bus_i.rd && bus_i.addr == CTRL_OFS) |=> rdata_o[BNE_BIT] == !$past(fifo_empty))
    else $error("not-empty flag wrong");
  a_push_store: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_stored_capture |=> !fifo_empty)
    else $error("stored capture left the buffer empty");
  a_off_empty: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == MODE_OFF) |=> (fifo_empty && !ovf_ff))
    else $error("channel off but buffer state kept");
  // halting in idle
  a_idle_halt: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (idle_halt && power_i.idle) |-> !cap_ev)
    else $error("capture while halted in idle");
  a_halt_tb: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    halted |=> $stable(tb_count))
    else $error("time base moved while halted in idle");
  a_halt_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (halted && mode != MODE_WAKE) |=> !irq_o)
    else $error("interrupt while halted in idle");
  // disabled modes
  a_unused_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == MODE_UNUSED || mode == MODE_OFF) |=> !irq_o)
    else $error("interrupt in disabled mode");
  a_unused_nocap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == MODE_UNUSED) |-> !push)
    else $error("capture in unused mode");
  a_tb_stop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == MODE_OFF) |=> $stable(tb_count))
    else $error("time base moved while channel off");
  // capture events by mode
  a_fall_cap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == MODE_FALL && run) |-> (cap_ev == fall))
    else $error("falling edge capture wrong");
  a_rise_cap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == MODE_RISE && run) |-> (cap_ev == rise))
    else $error("rising edge capture wrong");
  a_both_cap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == MODE_BOTH && run) |-> (cap_ev == (rise || fall)))
    else $error("every-edge capture wrong");
  a_pre4_rise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == MODE_PRE4 && cap_ev) |-> rise)
    else $error("prescaled capture off a rising edge");
  a_pre16_rise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == MODE_PRE16 && cap_ev) |-> (rise && pre_ff == PRE16_LAST))
    else $error("sixteenth-edge capture wrong");
  // wake pin
  a_wake_only: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == MODE_WAKE && !power_i.sleep && !power_i.idle) |=> !irq_o)
    else $error("wake interrupt outside low power");
  a_wake_irq: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_wake_edge |=> irq_o)
    else $error("wake edge gave no interrupt");
  a_wake_nocap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == MODE_WAKE) |-> !push)
    else $error("capture in wake mode");
  a_wake_fall: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == MODE_WAKE && fall) |=> !irq_o)
    else $error("wake interrupt on a falling edge");
  // interrupt divider
  a_every_cap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == MODE_BOTH && cap_ev && !fifo_full) |=> irq_o)
    else $error("edge mode must interrupt on each capture");
  a_cpi_every: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cap_ev && !fifo_full && cpi == '0) |=> irq_o)
    else $error("capture without interrupt at divider zero");
  a_cpi_skip: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cap_ev && !fifo_full && mode != MODE_BOTH && cpi != '0 && cpi_cnt_ff == '0) |=> !irq_o)
    else $error("divider interrupted on first capture of a group");
endmodule // ecu_top
`default_nettype wire

// >>> verif/ecu_pin_model.sv
// model of the external edge source that drives the capture pin
`default_nettype none
module ecu_pin_model
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [7:0] pulses_i,
  input wire logic [3:0] half_i,
  output logic pin_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] left_ff;
  logic [3:0] wait_ff;
  // sends whole pulses of half_i cycles per level, then rests low
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_o <= 1'b0;
      left_ff <= 9'h000;
      wait_ff <= 4'h0;
    end
    else if (start_i)
    begin
      left_ff <= {pulses_i, 1'b0};
      wait_ff <= half_i;
    end
    else if (left_ff != 9'h000)
    begin
      if (wait_ff == 4'h1)
      begin
        pin_o <= ~pin_o;
        left_ff <= left_ff - 9'h001;
        wait_ff <= half_i;
      end
      else
        wait_ff <= wait_ff - 4'h1;
    end
  end
  // busy while edges remain to be sent
  assign busy_o = (left_ff != 9'h000);
endmodule // ecu_pin_model
`default_nettype wire

// >>> verif/ecu_top_test.sv
// self-checking testbench for the edge capture unit
`default_nettype none
module ecu_top_test import ecu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_b_i, irq, pin, start, busy;
  logic [15:0] rdata, d;
  logic [7:0] pulses;
  logic [3:0] half;
  ecu_bus_type bus;
  ecu_ticks_type ticks;
  ecu_power_type power;
  int bad_count, checked, irq_n, cyc, seed, hp, m;
  ecu_top u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .rdata_o(rdata), .ticks_i(ticks),
    .power_i(power), .capture_pin_i(pin), .irq_o(irq));
  ecu_pin_model u_pin (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start), .pulses_i(pulses),
    .half_i(half), .pin_o(pin), .busy_o(busy));
  // 50 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // interrupt pulse counter and hang guard
  always @(posedge clk_i)
  begin
    if (irq === 1'b1)
      irq_n++;
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      test_done;
    end
  end
  task automatic test_done;
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    @(negedge clk_i);
    v = rdata;
  endtask
  function automatic logic [15:0] ctl(input logic ib, input int ts, input int cpi, input int md);
    return {2'h0, ib, ts[2:0], 3'h0, cpi[1:0], 2'h0, md[2:0]};
  endfunction
  function automatic int caps(input int md, input int p);
    case (md)
      1: return 2 * p;
      2, 3: return p;
      4: return p / 4;
      5: return p / 16;
      default: return 0;
    endcase
  endfunction
  // one-hot timer tick for a source select; reserved and clock selects get all ticks
  function automatic ecu_ticks_type tick_of(input int ts);
    case (ts)
      0: return ecu_ticks_type'(5'h04);
      1: return ecu_ticks_type'(5'h08);
      2: return ecu_ticks_type'(5'h02);
      3: return ecu_ticks_type'(5'h01);
      4: return ecu_ticks_type'(5'h10);
      default: return ecu_ticks_type'(5'h1F);
    endcase
  endfunction
  // sends p pulses of random width and waits for the pin to settle
  task automatic fire(input int p);
    hp = 2 + ($unsigned($random(seed)) % 4);
    @(posedge clk_i);
    start <= 1'b1;
    pulses <= p[7:0];
    half <= hp[3:0];
    @(posedge clk_i);
    start <= 1'b0;
    @(negedge clk_i);
    repeat (600) if (busy === 1'b1) @(posedge clk_i);
    repeat (6) @(posedge clk_i);
  endtask
  // one capture run: interrupts, status flags, then drain the buffer
  task automatic run(input logic ib, input int cpi, input int md, input logic [1:0] pw, input int p);
    int c, n, e;
    c = ((ib && pw[1]) || pw[0]) ? 0 : caps(md, p);
    n = (c > 4) ? 4 : c;
    e = (md == 1) ? n : n / (cpi + 1);
    if (md == 7)
      e = (pw != 2'h0) ? p : 0;
    wr(CTRL_OFS, ctl(1'b0, 7, 0, 0));
    wr(CTRL_OFS, ctl(ib, 7, cpi, md));
    power <= ecu_power_type'(pw);
    irq_n = 0;
    fire(p);
    chk(irq_n[15:0], e[15:0]);
    power <= ecu_power_type'(2'h0);
    rd(CTRL_OFS, d);
    chk(d, ctl(ib, 7, cpi, md) | {11'h0, c > 4, n > 0, 3'h0});
    repeat (n) rd(BUF_OFS, d);
    rd(CTRL_OFS, d);
    chk({14'h0, d[4:3]}, {14'h0, c > 4, 1'b0});
  endtask
  // two rising edges 2*half apart must differ by that many counts, or by none on the reserved selects
  task automatic tbase(input int ts);
    logic [15:0] a, b;
    wr(CTRL_OFS, ctl(1'b0, 7, 0, 0));
    wr(CTRL_OFS, ctl(1'b0, ts, 0, 2));
    ticks <= tick_of(ts);
    fire(2);
    rd(BUF_OFS, a);
    rd(BUF_OFS, b);
    chk(b - a, (ts == 5 || ts == 6) ? 16'h0000 : 16'(2 * hp));
    ticks <= ecu_ticks_type'(5'h00);
  endtask
  // main sequence
  initial
  begin
    seed = 14607;
    bus = '0;
    ticks = '0;
    power = '0;
    start = 1'b0;
    pulses = 8'h00;
    half = 4'h0;
    rst_b_i = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(CTRL_OFS, d);
    chk(d, CTRL_RESET);
    wr(CTRL_OFS, 16'hFFFF);
    rd(CTRL_OFS, d);
    chk(d, CTRL_WMASK);
    wr(4'h7, 16'hFFFF);
    rd(4'h7, d);
    chk(d, 16'h0000);
    for (m = 0; m < 8; m++) run(1'b0, 0, m, 2'h0, 16);
    for (m = 0; m < 4; m++) run(1'b0, m, 2, 2'h0, 4);
    run(1'b0, 3, 1, 2'h0, 2);
    run(1'b0, 1, 7, 2'h2, 3);
    run(1'b0, 0, 7, 2'h1, 3);
    run(1'b1, 0, 2, 2'h2, 3);
    run(1'b0, 0, 2, 2'h2, 3);
    for (m = 0; m < 8; m++) tbase(m);
    test_done;
  end
endmodule // ecu_top_test
`default_nettype wire
